// ### logic/smt_bridge_pwm.v
// Fixed off-time PWM, blanking, decay and rectification of one bridge
`timescale 1ns/1ps
`include "smt_defines.vh"

module smt_bridge_pwm #(
    parameter OFF_CYCLES   = 1520,
    parameter BLANK_CYCLES = 38,
    parameter RAMP_DIV     = 9
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Control
    input  wire        run,
    input  wire        polarity,
    input  wire [2:0]  decay_mode,
    input  wire [7:0]  blend_code,
    input  wire        rectify_off,
    // Sense
    input  wire        sense_trip,
    input  wire        zero_current,
    // Gates
    output reg         src_a,
    output reg         snk_a,
    output reg         src_b,
    output reg         snk_b
);

    localparam ST_DRIVE = 2'b01;
    localparam ST_OFF   = 2'b10;
    localparam [11:0] OFF_LOAD   = OFF_CYCLES[11:0] - 12'h001;
    localparam [7:0]  BLANK_LOAD = BLANK_CYCLES[7:0];
    localparam [7:0]  DIV_LOAD   = RAMP_DIV[7:0] - 8'h01;

    reg  [1:0]  state;
    reg  [11:0] off_cnt;
    reg  [7:0]  blank_cnt;
    reg  [7:0]  ramp;
    reg  [7:0]  div_cnt;
    reg         fast_phase;
    reg         rect_live;
    reg  [3:0]  next_gates;

    wire trip  = sense_trip && (blank_cnt == 8'h00); // R16
    wire sr_on = rect_live && !rectify_off;           // R22

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_DRIVE;
            off_cnt    <= 12'h000;
            blank_cnt  <= 8'h00;
            ramp       <= 8'h00;
            div_cnt    <= 8'h00;
            fast_phase <= 1'b0;
            rect_live  <= 1'b0;
        end else if (!run) begin
            // Restart blanked, the first drive edge is a switching event
            state      <= ST_DRIVE;
            off_cnt    <= 12'h000;
            blank_cnt  <= BLANK_LOAD; // R16
            fast_phase <= 1'b0;
            rect_live  <= 1'b0;
        end else begin
            if (blank_cnt != 8'h00) begin
                blank_cnt <= blank_cnt - 8'h01;
            end
            case (state)
                ST_DRIVE: begin
                    if (trip) begin // R14
                        state      <= ST_OFF;
                        off_cnt    <= OFF_LOAD; // R16
                        blank_cnt  <= BLANK_LOAD; // R16
                        ramp       <= `SMT_BLEND_HI;
                        div_cnt    <= DIV_LOAD;
                        rect_live  <= 1'b1;
                        fast_phase <= (decay_mode != `SMT_MODE_SLOW); // R15
                    end
                end
                ST_OFF: begin
                    if (off_cnt == 12'h000) begin
                        state     <= ST_DRIVE;
                        blank_cnt <= BLANK_LOAD; // R16
                    end else begin
                        off_cnt <= off_cnt - 12'h001;
                    end
                    // Linear stand-in for the RC ramp
                    if (div_cnt == 8'h00) begin
                        div_cnt <= DIV_LOAD;
                        if (ramp != 8'h00) begin
                            ramp <= ramp - 8'h01;
                        end
                    end else begin
                        div_cnt <= div_cnt - 8'h01;
                    end
                    if (decay_mode == `SMT_MODE_MIXED && fast_phase && ramp <= blend_code) begin
                        fast_phase <= 1'b0; // R21
                        blank_cnt  <= BLANK_LOAD; // R16
                    end
                    if (zero_current) begin
                        rect_live <= 1'b0; // R22
                    end
                end
                default: begin
                    state <= ST_DRIVE;
                end
            endcase
        end
    end

    // Gate order {src_a, snk_a, src_b, snk_b}
    always @* begin
        next_gates = 4'h0;
        if (run) begin
            case (state)
                ST_DRIVE: begin
                    next_gates = {polarity, !polarity, !polarity, polarity}; // R14
                end
                ST_OFF: begin
                    if (fast_phase) begin
                        // Reverse diagonal only while rectifying
                        next_gates = {!polarity && sr_on, polarity && sr_on,
                                      polarity && sr_on, !polarity && sr_on}; // R15
                    end else begin
                        // Sources off, driving sink kept on
                        next_gates = {1'b0, !polarity || sr_on,
                                      1'b0, polarity || sr_on}; // R15
                    end
                end
                default: begin
                    next_gates = 4'h0;
                end
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {src_a, snk_a, src_b, snk_b} <= 4'h0;
        end else begin
            {src_a, snk_a, src_b, snk_b} <= next_gates;
        end
    end

endmodule // smt_bridge_pwm

// ### logic/smt_defines.vh
// Shared constants of the stepper microstep translator
//------------------------------------------------------------------
// Overview of operation
// R1: Every step_pulse rising edge advances index, DAC codes and polarities one entry.
// R2: Resolution pins lo/hi pick full, half, quarter or sixteenth step.
// R3: Resolution pins are sampled only at a step_pulse rising edge.
// R4: direction_select picks sequence direction, sampled only at step edge.
// R5: Controller holds step_pulse high at least 1.0 us per step.
// R6: Controller holds step_pulse low at least 1.0 us between steps.
// R7: Controller waits 1 ms after leaving sleep before any step edge.
// R8: Reset loads origin codes and polarities; both bridges start in mixed decay.
// R9: A step lowering a bridge's level gives it the decay_blend_level mode.
// R10: A step raising or keeping a bridge's level gives it slow decay.
// R11: Reset low holds origin, turns off all outputs, drives origin_flag low.
// R12: Step edges are ignored during reset and accepted again after release.
// R13: origin_flag is high whenever the translator sits at its origin state (code keeps it low while reset_n is low).
// R14: Bridge drives a diagonal pair until sense trips at the DAC threshold.
// R15: On trip slow decay drops sources only; fast or mixed drops all drive.
// R16: Fixed off-time after each trip; sense blanked after every switching event (none on the first drive after presetn or on a drive polarity flip).
// R17: enable_n high turns outputs off; translator keeps stepping.
// R18: Faults disable outputs until cleared; supply_lockout also resets translator.
// R19: sleep_n low disables outputs and regulator; waking restarts at origin.
// R20: Blend level above 0.6 slow, below 0.21 fast, otherwise mixed.
// R21: Mixed decay is fast until off-time ramp meets blend level, then slow.
// R22: rectify_disable low enables synchronous rectification, cut at zero current.
// R23: Origin is 45 degrees, both phases 70.71 percent, four full steps per cycle.
// R24: 64-entry index moves by 16, 8, 4 or 1 modulo 64 and addresses currents.
//------------------------------------------------------------------
`ifndef SMT_DEFINES_VH
`define SMT_DEFINES_VH

// Timing
`define SMT_CLK_PERIOD_NS   25
`define SMT_OFF_TIME_NS     38000
`define SMT_BLANK_NS        950

// Translator
`define SMT_IDX_W           6
`define SMT_ORIGIN_IDX      6'h08
`define SMT_COS_OFS         6'h10
`define SMT_INC_FULL        6'h10
`define SMT_INC_HALF        6'h08
`define SMT_INC_QUARTER     6'h04
`define SMT_INC_SIXTEENTH   6'h01
`define SMT_HALF_TURN       6'h20
`define SMT_DAC_W           8
`define SMT_DAC_HOME        8'hb4
`define SMT_ROM_AW          5

// Decay modes, one-hot
`define SMT_MODE_SLOW       3'b001
`define SMT_MODE_FAST       3'b010
`define SMT_MODE_MIXED      3'b100

// Blend level as a fraction of the logic supply in 1/256 units
`define SMT_BLEND_HI        8'h9a
`define SMT_BLEND_LO        8'h36

// Register map
`define SMT_REG_CTRL        8'h00
`define SMT_REG_STATUS      8'h04
`define SMT_REG_DAC         8'h08
`define SMT_CTRL_W          2
`define SMT_CTRL_RESET      2'b01
`define SMT_CTRL_OUT_EN     0
`define SMT_CTRL_RECT_DIS   1

`endif

// ### logic/smt_sine_rom.v
// Quarter-wave phase current table with two registered read ports
`timescale 1ns/1ps
`include "smt_defines.vh"

module smt_sine_rom (
    // Clock and reset
    input  wire                      pclk,
    input  wire                      presetn,
    // Read ports
    input  wire [`SMT_ROM_AW-1:0]    addr_a,
    input  wire [`SMT_ROM_AW-1:0]    addr_b,
    output reg  [`SMT_DAC_W-1:0]     data_a,
    output reg  [`SMT_DAC_W-1:0]     data_b
);

    // Full scale is 255 at 90 degrees
    function [`SMT_DAC_W-1:0] level;
        input [`SMT_ROM_AW-1:0] a;
        begin
            case (a)
                5'h00:   level = 8'h00;
                5'h01:   level = 8'h19;
                5'h02:   level = 8'h32;
                5'h03:   level = 8'h4a;
                5'h04:   level = 8'h62;
                5'h05:   level = 8'h78;
                5'h06:   level = 8'h8e;
                5'h07:   level = 8'ha2;
                5'h08:   level = 8'hb4;
                5'h09:   level = 8'hc5;
                5'h0a:   level = 8'hd4;
                5'h0b:   level = 8'he1;
                5'h0c:   level = 8'hec;
                5'h0d:   level = 8'hf4;
                5'h0e:   level = 8'hfa;
                5'h0f:   level = 8'hfe;
                default: level = 8'hff;
            endcase
        end
    endfunction

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {data_a, data_b} <= 16'h0000;
        end else begin
            data_a <= level(addr_a);
            data_b <= level(addr_b);
        end
    end

endmodule // smt_sine_rom

// ### logic/smt_translator.v
// Step translator, decay selection, output gating and APB registers
`timescale 1ns/1ps
`include "smt_defines.vh"

module smt_translator #(
    parameter ADDR_W     = 8,
    parameter OFF_TIME_NS = `SMT_OFF_TIME_NS,
    parameter BLANK_NS    = `SMT_BLANK_NS
) (
    // APB
    input  wire                  pclk,
    input  wire                  presetn,
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [ADDR_W-1:0]     paddr,
    input  wire [31:0]           pwdata,
    output reg  [31:0]           prdata,
    output wire                  pready,
    output reg                   pslverr,
    // Controller pins
    input  wire                  step_pulse,
    input  wire                  direction_select,
    input  wire                  resolution_sel_lo,
    input  wire                  resolution_sel_hi,
    input  wire                  reset_n,
    input  wire                  enable_n,
    input  wire                  sleep_n,
    input  wire                  rectify_disable,
    input  wire [7:0]            decay_blend_level,
    output reg                   origin_flag,
    // Protection
    input  wire                  overtemp,
    input  wire                  gate_pump_supply_low,
    input  wire                  sink_gate_regulator_fault,
    input  wire                  supply_lockout,
    // Current sense, one bit per bridge
    input  wire [1:0]            sense_trip,
    input  wire [1:0]            zero_current,
    // Translator outputs
    output wire [`SMT_DAC_W-1:0] dac_phase1,
    output wire [`SMT_DAC_W-1:0] dac_phase2,
    output wire [1:0]            phase_polarity,
    // Bridge gates, one bit per bridge
    output wire [1:0]            src_a,
    output wire [1:0]            snk_a,
    output wire [1:0]            src_b,
    output wire [1:0]            snk_b
);

    //--------------------------------------------------------------
    // Derived timing
    //--------------------------------------------------------------
    // Off-time rounds down, blanking rounds up
    localparam OFF_CYCLES   = OFF_TIME_NS / `SMT_CLK_PERIOD_NS;
    localparam BLANK_CYCLES = (BLANK_NS + `SMT_CLK_PERIOD_NS - 1) / `SMT_CLK_PERIOD_NS;
    localparam RAMP_STEPS   = `SMT_BLEND_HI;
    localparam RAMP_DIV     = (OFF_CYCLES / RAMP_STEPS < 1) ? 1 : OFF_CYCLES / RAMP_STEPS;
    localparam DW           = `SMT_DAC_W;

    //--------------------------------------------------------------
    // Decoding helpers
    //--------------------------------------------------------------
    function [`SMT_IDX_W-1:0] step_size;
        input lo;
        input hi;
        begin
            case ({hi, lo})
                2'b00:   step_size = `SMT_INC_FULL;
                2'b01:   step_size = `SMT_INC_HALF;
                2'b10:   step_size = `SMT_INC_QUARTER;
                default: step_size = `SMT_INC_SIXTEENTH;
            endcase
        end
    endfunction

    // Fold a 64-entry angle onto the quarter-wave table
    function [`SMT_ROM_AW-1:0] fold_addr;
        input [`SMT_IDX_W-1:0] i;
        reg   [`SMT_IDX_W-1:0] q;
        reg   [`SMT_IDX_W-1:0] r;
        begin
            q = {1'b0, i[`SMT_IDX_W-2:0]};
            r = `SMT_HALF_TURN - q;
            fold_addr = (q > `SMT_INC_FULL) ? r[`SMT_ROM_AW-1:0] : q[`SMT_ROM_AW-1:0];
        end
    endfunction

    function [2:0] decode_blend;
        input [7:0] code;
        begin
            if (code >= `SMT_BLEND_HI) begin
                decode_blend = `SMT_MODE_SLOW;
            end else if (code < `SMT_BLEND_LO) begin
                decode_blend = `SMT_MODE_FAST;
            end else begin
                decode_blend = `SMT_MODE_MIXED;
            end
        end
    endfunction

    //--------------------------------------------------------------
    // Translator index
    //--------------------------------------------------------------
    reg  [`SMT_IDX_W-1:0] idx;
    reg  [`SMT_IDX_W-1:0] next_idx;
    reg                   step_prev;
    reg  [1:0]            res_taken;
    reg                   dir_taken;
    reg                   upd_d1;
    reg                   upd_d2;

    wire faulted   = overtemp || gate_pump_supply_low || sink_gate_regulator_fault;
    wire trans_clr = !reset_n || supply_lockout || !sleep_n; // R11 R18 R19
    wire step_rise = step_pulse && !step_prev;
    wire step_take = step_rise && !trans_clr; // R12
    wire [`SMT_IDX_W-1:0] inc = step_size(resolution_sel_lo, resolution_sel_hi); // R2

    always @* begin
        next_idx = idx;
        if (trans_clr) begin
            next_idx = `SMT_ORIGIN_IDX; // R11 R23
        end else if (step_take) begin
            next_idx = direction_select ? idx + inc : idx - inc; // R1 R4 R24
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx         <= `SMT_ORIGIN_IDX; // R8
            step_prev   <= 1'b0;
            res_taken   <= 2'b00;
            dir_taken   <= 1'b0;
            upd_d1      <= 1'b0;
            upd_d2      <= 1'b0;
            origin_flag <= 1'b0;
        end else begin
            // Edge history runs through reset so a held level is no edge
            step_prev   <= step_pulse;
            idx         <= next_idx;
            upd_d1      <= step_take || trans_clr;
            upd_d2      <= upd_d1;
            origin_flag <= reset_n && (next_idx == `SMT_ORIGIN_IDX); // R11 R13
            if (step_take) begin
                res_taken <= {resolution_sel_hi, resolution_sel_lo}; // R3
                dir_taken <= direction_select; // R4
            end
        end
    end

    //--------------------------------------------------------------
    // Phase current lookup
    //--------------------------------------------------------------
    // Phase 1 leads phase 2 by a quarter turn
    wire [`SMT_IDX_W-1:0] idx_p1 = idx + `SMT_COS_OFS;
    wire [DW-1:0]         rom_p1;
    wire [DW-1:0]         rom_p2;

    smt_sine_rom u_rom (
        .pclk    (pclk),
        .presetn (presetn),
        .addr_a  (fold_addr(idx_p1)), // R24
        .addr_b  (fold_addr(idx)),
        .data_a  (rom_p1),
        .data_b  (rom_p2)
    );

    //--------------------------------------------------------------
    // DAC codes, polarity and decay mode per bridge
    //--------------------------------------------------------------
    reg  [2*DW-1:0] dac_flat;
    reg  [1:0]      pol;
    reg  [5:0]      mode_flat;
    wire [2*DW-1:0] rom_flat = {rom_p2, rom_p1};
    wire [1:0]      new_pol  = {!idx[`SMT_IDX_W-1], !idx_p1[`SMT_IDX_W-1]};
    integer         b;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_flat  <= {`SMT_DAC_HOME, `SMT_DAC_HOME}; // R8 R23
            pol       <= 2'b11;
            mode_flat <= {`SMT_MODE_MIXED, `SMT_MODE_MIXED}; // R8
        end else if (upd_d2) begin
            // Index is stable here: step spacing is far above two cycles
            pol <= new_pol; // R1
            for (b = 0; b < 2; b = b + 1) begin
                dac_flat[b*DW +: DW] <= rom_flat[b*DW +: DW]; // R1
                if (!reset_n || supply_lockout || !sleep_n) begin
                    mode_flat[b*3 +: 3] <= `SMT_MODE_MIXED; // R8
                end else if (rom_flat[b*DW +: DW] < dac_flat[b*DW +: DW]) begin
                    mode_flat[b*3 +: 3] <= decode_blend(decay_blend_level); // R9 R20
                end else begin
                    mode_flat[b*3 +: 3] <= `SMT_MODE_SLOW; // R10
                end
            end
        end
    end

    assign dac_phase1     = dac_flat[DW-1:0];
    assign dac_phase2     = dac_flat[2*DW-1:DW];
    assign phase_polarity = pol;

    //--------------------------------------------------------------
    // Output gating and bridges
    //--------------------------------------------------------------
    reg  [`SMT_CTRL_W-1:0] ctrl;

    wire outputs_on = reset_n && !enable_n && sleep_n && !faulted && !supply_lockout
                      && ctrl[`SMT_CTRL_OUT_EN]; // R11 R17 R18 R19
    wire rect_off   = rectify_disable || ctrl[`SMT_CTRL_RECT_DIS]; // R22

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : bridge
            smt_bridge_pwm #(
                .OFF_CYCLES   (OFF_CYCLES),
                .BLANK_CYCLES (BLANK_CYCLES),
                .RAMP_DIV     (RAMP_DIV)
            ) u_pwm (
                .pclk         (pclk),
                .presetn      (presetn),
                .run          (outputs_on),
                .polarity     (pol[g]),
                .decay_mode   (mode_flat[g*3 +: 3]),
                .blend_code   (decay_blend_level),
                .rectify_off  (rect_off),
                .sense_trip   (sense_trip[g]),
                .zero_current (zero_current[g]),
                .src_a        (src_a[g]),
                .snk_a        (snk_a[g]),
                .src_b        (src_b[g]),
                .snk_b        (snk_b[g])
            );
        end
    endgenerate

    //--------------------------------------------------------------
    // APB slave
    //--------------------------------------------------------------
    // Zero wait states: data is staged in setup, taken in access
    wire setup_ph  = psel && !penable;
    wire access_ph = psel && penable;
    wire hit_ctrl  = (paddr == `SMT_REG_CTRL);
    wire hit_stat  = (paddr == `SMT_REG_STATUS);
    wire hit_dac   = (paddr == `SMT_REG_DAC);
    wire mapped    = hit_ctrl || hit_stat || hit_dac;
    reg  [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux = {30'h0, ctrl};
        end else if (hit_stat) begin
            rd_mux = {14'h0, faulted, mode_flat, dir_taken, res_taken,
                      outputs_on, origin_flag, idx};
        end else if (hit_dac) begin
            rd_mux = {7'h0, pol[1], dac_flat[2*DW-1:DW], 7'h0, pol[0], dac_flat[DW-1:0]};
        end
    end

    assign pready = 1'b1;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            ctrl    <= `SMT_CTRL_RESET;
        end else begin
            if (setup_ph) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= !mapped;
            end
            if (access_ph && pwrite && hit_ctrl) begin
                ctrl <= pwdata[`SMT_CTRL_W-1:0];
            end
        end
    end

endmodule // smt_translator

// ### test/smt_motion_ctrl.sv
// Motion controller model driving the step and direction pins
`timescale 1ns/1ps
module smt_motion_ctrl #(
    parameter WAKE_CYC = 40000
) (
    // Clock
    input  wire  pclk,
    // Controller pins
    output logic step_pulse,
    output logic direction_select,
    output logic resolution_sel_lo,
    output logic resolution_sel_hi,
    output logic sleep_n
);
    // 200 ns setup, 1.0 us high, 1.0 us low at 25 ns per cycle
    localparam SETUP_CYC = 8, HIGH_CYC = 40, LOW_CYC = 40;

    initial {step_pulse, direction_select, resolution_sel_hi, resolution_sel_lo, sleep_n}
        = 5'b01001;

    task set_cmd(input logic d, input logic [1:0] r);
        @(posedge pclk);
        direction_select <= d;
        {resolution_sel_hi, resolution_sel_lo} <= r;
    endtask

    task step(input logic d, input logic [1:0] r);
        set_cmd(d, r);
        repeat (SETUP_CYC) @(posedge pclk);
        step_pulse <= 1'b1;
        repeat (HIGH_CYC) @(posedge pclk);
        step_pulse <= 1'b0;
        repeat (LOW_CYC) @(posedge pclk);
    endtask

    task wake;
        @(posedge pclk);
        sleep_n <= 1'b1;
        repeat (WAKE_CYC) @(posedge pclk);
    endtask
endmodule // smt_motion_ctrl

// ### test/smt_translator_sva.sv
// Pin-level assertions of the translator
`timescale 1ns/1ps
module smt_translator_chk (
    // Clock and reset
    input wire       pclk,
    input wire       presetn,
    // Controller pins
    input wire       reset_n,
    input wire       enable_n,
    input wire       sleep_n,
    input wire       overtemp,
    input wire       supply_lockout,
    input wire       step_pulse,
    input wire       origin_flag,
    // Translator and gates
    input wire [7:0] dac_phase1,
    input wire [7:0] dac_phase2,
    input wire [1:0] phase_polarity,
    input wire [1:0] src_a,
    input wire [1:0] snk_a,
    input wire [1:0] src_b,
    input wire [1:0] snk_b
);
    wire g_off = ~|{src_a, snk_a, src_b, snk_b};
    wire home  = dac_phase1 == 8'hb4 && dac_phase2 == 8'hb4 && phase_polarity == 2'b11;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_step_taken;
        $rose(step_pulse) && reset_n && sleep_n && !supply_lockout;
    endsequence
    a_reset_flag_low: assert property (!reset_n [*2] |-> !origin_flag)
        else $error("origin flag high in reset");
    a_reset_gates_off: assert property (!reset_n [*4] |-> g_off)
        else $error("gates on in reset");
    a_reset_holds_home: assert property (!reset_n [*4] |-> home)
        else $error("translator left home in reset");
    a_enable_gates_off: assert property (enable_n [*4] |-> g_off)
        else $error("gates on while disabled");
    a_fault_gates_off: assert property (overtemp [*4] |-> g_off)
        else $error("gates on during fault");
    a_lockout_home: assert property (supply_lockout [*4] |-> home && g_off)
        else $error("lockout did not clear translator");
    a_sleep_gates_off: assert property (!sleep_n [*4] |-> g_off && home)
        else $error("gates on in sleep");
    a_step_leaves_home: assert property (s_step_taken ##0 origin_flag |=> !origin_flag)
        else $error("origin flag kept after step");
endmodule // smt_translator_chk

bind smt_translator smt_translator_chk u_chk (.*);

// ### test/test_stepper_microstep_translator.sv
// Register-level bench of the stepper translator
`timescale 1ns/1ps
module test_stepper_microstep_translator;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, blend = 8'h80, d1, d2;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, e, reset_n = 1, enable_n = 0, overtemp = 0, lockout = 0, rdis = 0;
    logic step, dir, rlo, rhi, sleep_n, origin_flag;
    logic [1:0] trip = 2'b00, zc = 2'b00, pol, sa, ka, sb, kb;
    logic [5:0] idx, inc [4] = '{6'h10, 6'h08, 6'h04, 6'h01};
    wire [7:0] gates = {sa, ka, sb, kb};
    int failures = 0, samples_checked = 0;

    always #12.5 pclk = ~pclk;

    smt_motion_ctrl ctl (.pclk(pclk), .step_pulse(step),
        .direction_select(dir), .resolution_sel_lo(rlo), .resolution_sel_hi(rhi),
        .sleep_n(sleep_n));
    smt_translator #(.OFF_TIME_NS(2000), .BLANK_NS(100)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .step_pulse(step), .direction_select(dir), .resolution_sel_lo(rlo),
        .resolution_sel_hi(rhi), .reset_n(reset_n), .enable_n(enable_n), .sleep_n(sleep_n),
        .rectify_disable(rdis), .decay_blend_level(blend), .origin_flag(origin_flag),
        .overtemp(overtemp), .gate_pump_supply_low(1'b0), .sink_gate_regulator_fault(1'b0),
        .supply_lockout(lockout), .sense_trip(trip), .zero_current(zc),
        .dac_phase1(d1), .dac_phase2(d2), .phase_polarity(pol),
        .src_a(sa), .snk_a(ka), .src_b(sb), .snk_b(kb));

    task give_verdict;
        $display("checked %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Setup, then access held until pready is seen high; w high makes it a write of d
    task automatic rd(input logic [7:0] a, input logic w = 0, input logic [31:0] d = 0);
        int n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 50) begin
            failures++;
            give_verdict;
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        failures++;
        give_verdict;
    end

    initial begin
        idle(10);
        presetn <= 1;
        rd(8'h04); chk(q & 32'h1f87f, 32'h12048);
        rd(8'h08); chk(q, 32'h01b401b4);
        chk(origin_flag, 1);
        chk(gates, 8'hc3);
        trip <= 2'b11;
        idle(5); chk(gates, 8'h3c);
        idle(40); chk(gates, 8'h33);
        rdis <= 1;
        idle(3); chk(gates, 8'h03);
        rdis <= 0;
        zc <= 2'b11;
        idle(3); chk(gates, 8'h03);
        zc <= 2'b00;
        trip <= 2'b00;
        idle(40); chk(gates, 8'hc3);
        rd(8'h00, 1, 32'h2);
        rd(8'h00); chk(q, 32'h2);
        chk(gates, 0);
        rd(8'h00, 1, 32'h1);
        rd(8'h0c); chk({e, q[30:0]}, 32'h80000000);
        idx = 6'h08;
        for (int r = 0; r < 4; r++) begin
            ctl.step(1, r[1:0]);
            idx = idx + inc[r];
            rd(8'h04); chk(q & 32'h73f, {21'h1, r[1:0], 2'b00, idx});
        end
        ctl.set_cmd(0, 2'b00);
        idle(5);
        rd(8'h04); chk(q & 32'h73f, {21'h1, 2'b11, 2'b00, idx});
        ctl.step(0, 2'b00);
        rd(8'h04); chk(q & 32'h73f, 32'h15);
        reset_n <= 0;
        ctl.step(1, 2'b00);
        chk(origin_flag, 0);
        reset_n <= 1;
        idle(5);
        rd(8'h04); chk(q & 32'h7f, 32'h48);
        blend <= 8'h00;
        ctl.step(1, 2'b01);
        rd(8'h08); chk(q & 32'h01ff00ff, 32'h01ff0000);
        chk({pol, d2, d1}, 32'h2ff00);
        rd(8'h04); chk(q & 32'h1f800, 32'h5000);
        trip <= 2'b11;
        enable_n <= 1;
        ctl.step(1, 2'b00);
        chk(gates, 0);
        rd(8'h04); chk(q & 32'h3f, 32'h20);
        enable_n <= 0;
        overtemp <= 1;
        idle(10);
        chk(gates, 0);
        overtemp <= 0;
        ctl.sleep_n <= 0;
        idle(10);
        ctl.wake;
        rd(8'h04); chk(q & 32'h3f, 32'h08);
        ctl.step(1, 2'b00);
        lockout <= 1;
        idle(10);
        lockout <= 0;
        idle(5);
        rd(8'h04); chk(q & 32'h3f, 32'h08);
        give_verdict;
    end
endmodule // test_stepper_microstep_translator
